// ==== design/autoneg_regs_pkg.sv ====
// constants for the autoneg ability and forced mode register bank
package autoneg_regs_pkg;
   // management frame addressing
   localparam logic [4:0]  DEVAD_AN        = 5'h07;
   localparam logic [15:0] OFF_NP_LOW      = 16'h020b;
   localparam logic [15:0] OFF_NP_MID      = 16'h020c;
   localparam logic [15:0] OFF_NP_HIGH     = 16'h020d;
   localparam logic [15:0] OFF_ADV_CTRL    = 16'h020e;
   localparam logic [15:0] OFF_LP_STATUS   = 16'h020f;
   localparam logic [15:0] OFF_FORCE       = 16'h8000;
   // field positions
   localparam int ADV_LONG_REACH_BIT = 15;
   localparam int ADV_ENERGY_BIT     = 14;
   localparam int ADV_HI_ABL_BIT     = 13;
   localparam int ADV_HI_REQ_BIT     = 12;
   localparam int LP_LONG_REACH_BIT  = 15;
   localparam int LP_ENERGY_BIT      = 14;
   localparam int LP_HI_ABL_BIT      = 13;
   localparam int LP_HI_REQ_BIT      = 12;
   localparam int LP_SHORT_FD_BIT    = 7;
   localparam int LP_SHORT_HD_BIT    = 6;
   localparam int FORCE_EN_BIT       = 0;
   // reset values
   localparam logic [15:0] NP_WORD_RST    = 16'h0000;
   localparam logic        ADV_LONG_RST   = 1'h1;
   localparam logic        FORCE_EN_RST   = 1'h0;
   // frame format
   localparam logic [1:0] OP_ADDRESS  = 2'h0;
   localparam logic [1:0] OP_WRITE    = 2'h1;
   localparam logic [1:0] OP_READ_INC = 2'h2;
   localparam logic [1:0] OP_READ     = 2'h3;
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [5:0] HDR_BITS     = 6'h0d;
   localparam logic [5:0] DATA_BITS    = 6'h10;
   // cycles after reset release before the straps are sampled
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   // serial engine states
   typedef enum logic [3:0] {
      ST_PRE  = 4'b0001,
      ST_HDR  = 4'b0010,
      ST_TA   = 4'b0100,
      ST_DATA = 4'b1000
   } mdio_state_t;
endpackage : autoneg_regs_pkg

// ==== design/pin_sync2.sv ====
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync2 #(
   parameter int              WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_i,    // system clock
   input  wire logic             rst_n_i,  // async reset, low
   input  wire logic [WIDTH-1:0] async_i,  // pins
   output logic      [WIDTH-1:0] sync_o    // synchronised copy
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t st_r;
   sync_t st_nxt;

   // first stage feeds only the second
   always_comb begin
      st_nxt.meta   = async_i;
      st_nxt.stable = st_r.meta;
   end

   // registers both stages
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '{meta: RESET_VAL, stable: RESET_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.stable;
endmodule : pin_sync2

// ==== design/np_snapshot.sv ====
// snapshot of the partner next page middle and high words
`timescale 1ns/1ps
module np_snapshot
   import autoneg_regs_pkg::*;
(
   input  wire logic        clk_i,     // system clock
   input  wire logic        rst_n_i,   // async reset, low
   input  wire logic        capture_i, // one-cycle take pulse
   input  wire logic [15:0] mid_i,     // live middle word
   input  wire logic [15:0] high_i,    // live high word
   output logic      [15:0] mid_o,     // held middle word
   output logic      [15:0] high_o     // held high word
);
   typedef struct packed {
      logic [15:0] mid;
      logic [15:0] high;
   } snap_t;

   snap_t st_r;
   snap_t st_nxt;

   // both words are taken together so they stay coherent
   always_comb begin
      st_nxt = st_r;
      if (capture_i) begin
         st_nxt.mid  = mid_i;
         st_nxt.high = high_i;
      end
   end

   // holds the snapshot between low-word reads
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '{mid: NP_WORD_RST, high: NP_WORD_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mid_o  = st_r.mid;
   assign high_o = st_r.high;
endmodule : np_snapshot

// ==== design/autoneg_ability_regs.sv ====
// autoneg ability, partner next page and forced mode registers
//
// Contract
// - six 16-bit registers in device 7 at 020b, 020c, 020d, 020e, 020f, 8000
// - reading the low partner page word snapshots middle and high words
// - middle and high reads return the snapshot, not the live value
// - middle word holds partner field one, read-only, resets to zero
// - high word holds partner field two, read-only, resets to zero
// - advert bit 15 aliases base long-reach ability, resets to one
// - advert bit 14 energy-saving always reads zero, writes ignored
// - advert bit 13 aliases base high-level ability, reset from strap
// - advert bit 12 aliases base high-level request, reset from strap
// - partner status bits 15..12 mirror partner base-page ability bits
// - partner status bits 7 and 6 mirror partner short-reach duplex bits
// - forced mode only when autoneg is off and forced enable is set
// - with autoneg on, the forced enable setting is ignored
// - forced register bit 0 read/write, resets zero, bits 15..1 read-only
// - the low partner page word at 020b is the read that triggers capture
`timescale 1ns/1ps
module autoneg_ability_regs
   import autoneg_regs_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h00  // management port address
) (
   input  wire logic        SYS_CLK_I,                 // system clock
   input  wire logic        RESET_N_I,                 // async reset, low
   input  wire logic        MDC_I,                     // management clock pin
   input  wire logic        MDIO_I,                    // management data in
   output logic             MDIO_O,                    // management data out
   output logic             MDIO_OE_O,                 // high while driving
   input  wire logic        STRAP_HIGH_ABILITY_I,      // strap pin
   input  wire logic        STRAP_HIGH_REQUEST_I,      // strap pin
   input  wire logic        AUTONEG_ENABLE_I,          // autoneg enable bit
   input  wire logic [15:0] PARTNER_NP_LOW_I,          // live low word
   input  wire logic [15:0] PARTNER_NP_MID_I,          // live field one
   input  wire logic [15:0] PARTNER_NP_HIGH_I,         // live field two
   input  wire logic        PARTNER_LONG_REACH_I,      // partner base page
   input  wire logic        PARTNER_ENERGY_SAVING_I,   // partner base page
   input  wire logic        PARTNER_HIGH_ABILITY_I,    // partner base page
   input  wire logic        PARTNER_HIGH_REQUEST_I,    // partner base page
   input  wire logic        PARTNER_SHORT_FD_I,        // partner base page
   input  wire logic        PARTNER_SHORT_HD_I,        // partner base page
   input  wire logic        BASE_ADV_WR_I,             // base page write
   input  wire logic        BASE_LONG_REACH_I,         // base write data
   input  wire logic        BASE_HIGH_ABILITY_I,       // base write data
   input  wire logic        BASE_HIGH_REQUEST_I,       // base write data
   output logic             BASE_LONG_REACH_ABILITY_O, // shared alias bit
   output logic             BASE_HIGH_ABILITY_O,       // shared alias bit
   output logic             BASE_HIGH_REQUEST_O,       // shared alias bit
   output logic             FORCED_MODE_O,             // forced mode active
   output logic             AUTONEG_RUN_O              // autoneg process runs
);
   typedef struct packed {
      mdio_state_t state;
      logic [5:0]  cnt;
      logic [15:0] shift;
      logic [1:0]  op;
      logic        hit;
      logic [15:0] addr;
      logic [15:0] rd_data;
      logic        mdc_prev;
      logic        mdio_out;
      logic        mdio_oe;
      logic        capture;
      logic        adv_long;
      logic        adv_hi_abl;
      logic        adv_hi_req;
      logic        force_en;
      logic [1:0]  settle;
      logic        strap_done;
   } bank_t;

   localparam bank_t BANK_RST = '{
      state:      ST_PRE,
      cnt:        6'h00,
      shift:      16'h0000,
      op:         OP_ADDRESS,
      hit:        1'h0,
      addr:       16'h0000,
      rd_data:    16'h0000,
      mdc_prev:   1'h1,
      mdio_out:   1'h0,
      mdio_oe:    1'h0,
      capture:    1'h0,
      adv_long:   ADV_LONG_RST,
      adv_hi_abl: 1'h0,
      adv_hi_req: 1'h0,
      force_en:   FORCE_EN_RST,
      settle:     2'h0,
      strap_done: 1'h0
   };

   bank_t       st_r;
   bank_t       st_nxt;

   // pins after the synchroniser
   logic [3:0]  pins_q;
   logic        mdc_q;
   logic        mdio_q;
   logic        strap_abl_q;
   logic        strap_req_q;
   logic        mdc_rise;

   // read path and frame decode
   logic [15:0] snap_mid;
   logic [15:0] snap_high;
   logic [15:0] rd_mux;
   logic [12:0] hdr;
   logic [15:0] wr_word;
   logic        is_read;

   // pins cross into the system clock before use
   pin_sync2 #(
      .WIDTH     (4),
      .RESET_VAL (4'h3)
   ) u_pin_sync (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RESET_N_I),
      .async_i ({STRAP_HIGH_REQUEST_I, STRAP_HIGH_ABILITY_I, MDIO_I, MDC_I}),
      .sync_o  (pins_q)
   );

   assign mdc_q       = pins_q[0];
   assign mdio_q      = pins_q[1];
   assign strap_abl_q = pins_q[2];
   assign strap_req_q = pins_q[3];

   // pulse on each rise of the synchronised clock pin
   assign mdc_rise    = mdc_q & ~st_r.mdc_prev;

   // coherent copy of the partner page upper words
   np_snapshot u_np_snapshot (
      .clk_i     (SYS_CLK_I),
      .rst_n_i   (RESET_N_I),
      .capture_i (st_r.capture),
      .mid_i     (PARTNER_NP_MID_I),
      .high_i    (PARTNER_NP_HIGH_I),
      .mid_o     (snap_mid),
      .high_o    (snap_high)
   );

   // header fields: start bit, opcode, port and device
   assign hdr     = {st_r.shift[11:0], mdio_q};
   assign wr_word = {st_r.shift[14:0], mdio_q};
   assign is_read = (hdr[11:10] == OP_READ) || (hdr[11:10] == OP_READ_INC);

   // read data for the current register address
   always_comb begin
      rd_mux = 16'h0000;
      case (st_r.addr)
         // live low word; reading it arms the snapshot
         OFF_NP_LOW: begin
            rd_mux = PARTNER_NP_LOW_I;
         end

         // upper words come from the snapshot
         OFF_NP_MID: begin
            rd_mux = snap_mid;
         end

         OFF_NP_HIGH: begin
            rd_mux = snap_high;
         end

         // aliases; the energy-saving bit has no storage
         OFF_ADV_CTRL: begin
            rd_mux[ADV_LONG_REACH_BIT] = st_r.adv_long;
            rd_mux[ADV_ENERGY_BIT]     = 1'b0;
            rd_mux[ADV_HI_ABL_BIT]     = st_r.adv_hi_abl;
            rd_mux[ADV_HI_REQ_BIT]     = st_r.adv_hi_req;
         end

         // partner base page mirrors
         OFF_LP_STATUS: begin
            rd_mux[LP_LONG_REACH_BIT] = PARTNER_LONG_REACH_I;
            rd_mux[LP_ENERGY_BIT]     = PARTNER_ENERGY_SAVING_I;
            rd_mux[LP_HI_ABL_BIT]     = PARTNER_HIGH_ABILITY_I;
            rd_mux[LP_HI_REQ_BIT]     = PARTNER_HIGH_REQUEST_I;
            rd_mux[LP_SHORT_FD_BIT]   = PARTNER_SHORT_FD_I;
            rd_mux[LP_SHORT_HD_BIT]   = PARTNER_SHORT_HD_I;
         end

         // only the enable bit is stored
         OFF_FORCE: begin
            rd_mux[FORCE_EN_BIT] = st_r.force_en;
         end

         // unmapped registers in this device
         default: begin
            rd_mux = 16'h0000;
         end
      endcase
   end

   // next state of the bank and the serial engine
   always_comb begin
      st_nxt          = st_r;
      st_nxt.capture  = 1'b0;
      st_nxt.mdc_prev = mdc_q;

      // base page writes land in the shared alias bits
      if (BASE_ADV_WR_I) begin
         st_nxt.adv_long   = BASE_LONG_REACH_I;
         st_nxt.adv_hi_abl = BASE_HIGH_ABILITY_I;
         st_nxt.adv_hi_req = BASE_HIGH_REQUEST_I;
      end

      // straps are taken once, after the synchroniser has settled
      if (!st_r.strap_done) begin
         if (st_r.settle == STRAP_SETTLE) begin
            st_nxt.adv_hi_abl = strap_abl_q;
            st_nxt.adv_hi_req = strap_req_q;
            st_nxt.strap_done = 1'b1;
         end else begin
            st_nxt.settle = st_r.settle + 2'h1;
         end
      end

      // management frames advance on each rising edge of the clock pin
      if (mdc_rise) begin
         case (st_r.state)
            // count preamble ones, wait for the start bit
            ST_PRE: begin
               if (mdio_q) begin
                  if (st_r.cnt != PREAMBLE_LEN) begin
                     st_nxt.cnt = st_r.cnt + 6'h01;
                  end
               end else if (st_r.cnt == PREAMBLE_LEN) begin
                  st_nxt.state = ST_HDR;  // first start bit seen
                  st_nxt.cnt   = 6'h00;
                  st_nxt.shift = 16'h0000;
               end else begin
                  st_nxt.cnt = 6'h00;
               end
            end

            // shift in the rest of the header
            ST_HDR: begin
               st_nxt.shift = wr_word;
               st_nxt.cnt   = st_r.cnt + 6'h01;
               if (st_r.cnt == HDR_BITS - 6'h01) begin
                  st_nxt.state = ST_TA;
                  st_nxt.cnt   = 6'h00;
                  st_nxt.op    = hdr[11:10];
                  st_nxt.hit   = !hdr[12] && (hdr[9:5] == PHY_ADDR)
                                 && (hdr[4:0] == DEVAD_AN);
                  // reads latch their data at the end of the header
                  if (!hdr[12] && (hdr[9:5] == PHY_ADDR)
                      && (hdr[4:0] == DEVAD_AN) && is_read) begin
                     st_nxt.rd_data = rd_mux;
                     // a low-word read freezes the upper words
                     st_nxt.capture = (st_r.addr == OFF_NP_LOW);
                     if (hdr[11:10] == OP_READ_INC) begin
                        st_nxt.addr = st_r.addr + 16'h0001;
                     end
                  end
               end
            end

            // turnaround; a read answers on its second bit
            ST_TA: begin
               st_nxt.cnt = st_r.cnt + 6'h01;
               if (st_r.hit && st_r.op[1]) begin
                  if (st_r.cnt == 6'h00) begin
                     st_nxt.mdio_oe  = 1'b1;  // second turnaround bit is 0
                     st_nxt.mdio_out = 1'b0;
                  end else begin
                     st_nxt.mdio_out = st_r.rd_data[15];
                     st_nxt.rd_data  = {st_r.rd_data[14:0], 1'b0};
                  end
               end
               // two turnaround bits, then data
               if (st_r.cnt == 6'h01) begin
                  st_nxt.state = ST_DATA;
                  st_nxt.cnt   = 6'h00;
               end
            end

            // sixteen data bits, msb first
            ST_DATA: begin
               st_nxt.shift = wr_word;
               st_nxt.cnt   = st_r.cnt + 6'h01;
               if (st_r.hit && st_r.op[1]) begin
                  st_nxt.mdio_out = st_r.rd_data[15];
                  st_nxt.rd_data  = {st_r.rd_data[14:0], 1'b0};
               end
               if (st_r.cnt == DATA_BITS - 6'h01) begin
                  st_nxt.state    = ST_PRE;
                  st_nxt.cnt      = 6'h00;
                  st_nxt.mdio_oe  = 1'b0;
                  st_nxt.mdio_out = 1'b0;
                  // an address frame loads the register pointer
                  if (st_r.hit && (st_r.op == OP_ADDRESS)) begin
                     st_nxt.addr = wr_word;
                  end

                  // writes touch only the writable bits
                  if (st_r.hit && (st_r.op == OP_WRITE)) begin
                     if (st_r.addr == OFF_ADV_CTRL) begin
                        st_nxt.adv_long   = wr_word[ADV_LONG_REACH_BIT];
                        st_nxt.adv_hi_abl = wr_word[ADV_HI_ABL_BIT];
                        st_nxt.adv_hi_req = wr_word[ADV_HI_REQ_BIT];
                     end
                     if (st_r.addr == OFF_FORCE) begin
                        st_nxt.force_en = wr_word[FORCE_EN_BIT];
                     end
                  end
               end
            end

            // illegal state code: back to idle
            default: begin
               st_nxt.state   = ST_PRE;
               st_nxt.cnt     = 6'h00;
               st_nxt.mdio_oe = 1'b0;
            end
         endcase
      end
   end

   // single state register for the bank; the snapshot words are held in np_snapshot
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st_r <= BANK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs to the pins and to the rest of the port
   assign MDIO_O    = st_r.mdio_out;
   assign MDIO_OE_O = st_r.mdio_oe;

   assign BASE_LONG_REACH_ABILITY_O = st_r.adv_long;
   assign BASE_HIGH_ABILITY_O       = st_r.adv_hi_abl;
   assign BASE_HIGH_REQUEST_O       = st_r.adv_hi_req;

   // autoneg overrides the forced enable
   assign FORCED_MODE_O = !AUTONEG_ENABLE_I && st_r.force_en;
   assign AUTONEG_RUN_O = AUTONEG_ENABLE_I;
endmodule : autoneg_ability_regs

// ==== test/autoneg_ability_regs_properties.sv ====
// port-level assertions for the autoneg register bank
`timescale 1ns/1ps
module autoneg_ability_regs_checker (
   input wire logic SYS_CLK_I,                 // clock
   input wire logic RESET_N_I,                 // reset, low
   input wire logic MDC_I,                     // management clock
   input wire logic MDIO_O,                    // data out
   input wire logic MDIO_OE_O,                 // data enable
   input wire logic STRAP_HIGH_ABILITY_I,      // strap
   input wire logic STRAP_HIGH_REQUEST_I,      // strap
   input wire logic AUTONEG_ENABLE_I,          // autoneg on
   input wire logic BASE_ADV_WR_I,             // base write
   input wire logic BASE_LONG_REACH_I,         // base data
   input wire logic BASE_HIGH_ABILITY_I,       // base data
   input wire logic BASE_HIGH_REQUEST_I,       // base data
   input wire logic BASE_LONG_REACH_ABILITY_O, // alias
   input wire logic BASE_HIGH_ABILITY_O,       // alias
   input wire logic BASE_HIGH_REQUEST_O,       // alias
   input wire logic FORCED_MODE_O,             // forced mode
   input wire logic AUTONEG_RUN_O              // autoneg runs
);
   logic [3:0] settle_cnt; // edges since reset release
   logic [3:0] mdc_low;    // samples with the management clock low
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // saturating helper counters
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         settle_cnt <= 4'h0;
         mdc_low    <= 4'h0;
      end else begin
         if (settle_cnt != 4'hf) settle_cnt <= settle_cnt + 4'h1;
         if (MDC_I) mdc_low <= 4'h0;
         else if (mdc_low != 4'hf) mdc_low <= mdc_low + 4'h1;
      end
   end
   AST_AN_OVERRIDES: assert property (AUTONEG_ENABLE_I |-> AUTONEG_RUN_O && !FORCED_MODE_O)
      else $error("forced mode or run flag wrong while autoneg is on");
   AST_AN_OFF: assert property (!AUTONEG_ENABLE_I |-> !AUTONEG_RUN_O)
      else $error("autoneg runs while disabled");
   AST_FORCE_STABLE: assert property (mdc_low >= 4'h6 && !AUTONEG_ENABLE_I
      |=> $stable(FORCED_MODE_O) || AUTONEG_ENABLE_I)
      else $error("forced mode moved without a write");
   AST_ALIAS_BASE_WRITE: assert property (BASE_ADV_WR_I
      && settle_cnt >= 4'h8 && mdc_low >= 4'h6
      |=> BASE_LONG_REACH_ABILITY_O == $past(BASE_LONG_REACH_I)
      && BASE_HIGH_ABILITY_O == $past(BASE_HIGH_ABILITY_I)
      && BASE_HIGH_REQUEST_O == $past(BASE_HIGH_REQUEST_I))
      else $error("base write not seen on alias bits");
   AST_ALIAS_HOLD: assert property (!BASE_ADV_WR_I
      && settle_cnt >= 4'h8 && mdc_low >= 4'h6
      |=> $stable(BASE_LONG_REACH_ABILITY_O) && $stable(BASE_HIGH_ABILITY_O)
      && $stable(BASE_HIGH_REQUEST_O))
      else $error("alias bits moved without a write");
   AST_RESET_VALUES: assert property ($rose(RESET_N_I) |-> BASE_LONG_REACH_ABILITY_O
      && !BASE_HIGH_ABILITY_O && !BASE_HIGH_REQUEST_O && !FORCED_MODE_O && !MDIO_OE_O)
      else $error("wrong values out of reset");
   AST_STRAP_CAPTURE: assert property (settle_cnt == 4'h6
      |-> BASE_HIGH_ABILITY_O == STRAP_HIGH_ABILITY_I
      && BASE_HIGH_REQUEST_O == STRAP_HIGH_REQUEST_I)
      else $error("strap values not loaded after reset");
   AST_OE_TA: assert property ($rose(MDIO_OE_O) |-> !MDIO_O)
      else $error("turnaround bit not driven low");
   AST_DRIVE_AFTER_RISE: assert property (MDIO_OE_O && $changed(MDIO_O)
      |-> $past(MDC_I, 3) || $past(MDC_I, 4))
      else $error("data out changed away from a clock rise");
endmodule : autoneg_ability_regs_checker

bind autoneg_ability_regs autoneg_ability_regs_checker autoneg_ability_regs_checker_i (
   .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .MDC_I(MDC_I), .MDIO_O(MDIO_O),
   .MDIO_OE_O(MDIO_OE_O), .STRAP_HIGH_ABILITY_I(STRAP_HIGH_ABILITY_I),
   .STRAP_HIGH_REQUEST_I(STRAP_HIGH_REQUEST_I), .AUTONEG_ENABLE_I(AUTONEG_ENABLE_I),
   .BASE_ADV_WR_I(BASE_ADV_WR_I), .BASE_LONG_REACH_I(BASE_LONG_REACH_I),
   .BASE_HIGH_ABILITY_I(BASE_HIGH_ABILITY_I), .BASE_HIGH_REQUEST_I(BASE_HIGH_REQUEST_I),
   .BASE_LONG_REACH_ABILITY_O(BASE_LONG_REACH_ABILITY_O),
   .BASE_HIGH_ABILITY_O(BASE_HIGH_ABILITY_O), .BASE_HIGH_REQUEST_O(BASE_HIGH_REQUEST_O),
   .FORCED_MODE_O(FORCED_MODE_O), .AUTONEG_RUN_O(AUTONEG_RUN_O));

// ==== test/mdio_host_model.sv ====
// management host model: clause 45 frames on a pulled-up data wire
`timescale 1ns/1ps
module mdio_host_model #(
   parameter logic [4:0] PHY_ADDR = 5'h00  // port address used in frames
) (
   input  wire logic clk_i,     // system clock
   input  wire logic mdio_i,    // resolved data wire
   output logic      mdc_o,     // management clock, low between frames
   output logic      mdio_o,    // data driven by the host
   output logic      mdio_oe_o  // high while the host drives
);
   localparam int HALF = 9; // clock high and low time, above the minimum of 8
   initial begin
      mdc_o     = 1'h0;
      mdio_o    = 1'h1;
      mdio_oe_o = 1'h0;
   end
   // one frame, msb first; on reads the wire is let go from turnaround on
   task automatic frame(input logic [1:0] op, input logic [4:0] devad,
                        input logic [15:0] wdata, output logic [15:0] rdata);
      logic [63:0] bits;
      bits  = {32'hffffffff, 2'h0, op, PHY_ADDR, devad, 2'h2, wdata};
      rdata = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         mdc_o     <= 1'h0;
         mdio_o    <= bits[i];
         mdio_oe_o <= !(op[1] && i < 18);
         repeat (HALF) @(posedge clk_i);
         if (i < 16) rdata[i] = mdio_i; // taken just before the rise
         mdc_o <= 1'h1;
         repeat (HALF) @(posedge clk_i);
      end
      mdc_o     <= 1'h0;
      mdio_oe_o <= 1'h0;
      repeat (HALF) @(posedge clk_i);
   endtask : frame
endmodule : mdio_host_model

// ==== test/tb_top.sv ====
// self-checking bench for the autoneg register bank
`timescale 1ns/1ps
module tb_top;
   import autoneg_regs_pkg::*;
   logic        clk, rst_n, autoneg_enable, base_wr, mdc, h_dout, h_oe, mdio_o, mdio_oe, mdio_line;
   logic        forced, an_run;
   logic [1:0]  strap;
   logic [2:0]  base_d, base_q;
   logic [5:0]  lp;
   logic [15:0] np_low, np_mid, np_high, rd;
   logic [5:0]  lp_tab [3] = '{6'h2a, 6'h15, 6'h3f};
   int          error_cnt, checks_done;
   // pulled-up data wire
   assign mdio_line = mdio_oe ? mdio_o : (h_oe ? h_dout : 1'h1);
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   autoneg_ability_regs autoneg_ability_regs_i (
      .SYS_CLK_I(clk), .RESET_N_I(rst_n), .MDC_I(mdc), .MDIO_I(mdio_line), .MDIO_O(mdio_o),
      .MDIO_OE_O(mdio_oe), .STRAP_HIGH_ABILITY_I(strap[1]), .STRAP_HIGH_REQUEST_I(strap[0]),
      .AUTONEG_ENABLE_I(autoneg_enable), .PARTNER_NP_LOW_I(np_low), .PARTNER_NP_MID_I(np_mid),
      .PARTNER_NP_HIGH_I(np_high), .PARTNER_LONG_REACH_I(lp[5]),
      .PARTNER_ENERGY_SAVING_I(lp[4]), .PARTNER_HIGH_ABILITY_I(lp[3]),
      .PARTNER_HIGH_REQUEST_I(lp[2]), .PARTNER_SHORT_FD_I(lp[1]), .PARTNER_SHORT_HD_I(lp[0]),
      .BASE_ADV_WR_I(base_wr), .BASE_LONG_REACH_I(base_d[2]), .BASE_HIGH_ABILITY_I(base_d[1]),
      .BASE_HIGH_REQUEST_I(base_d[0]), .BASE_LONG_REACH_ABILITY_O(base_q[2]),
      .BASE_HIGH_ABILITY_O(base_q[1]), .BASE_HIGH_REQUEST_O(base_q[0]),
      .FORCED_MODE_O(forced), .AUTONEG_RUN_O(an_run));
   mdio_host_model mdio_host_model_i (
      .clk_i(clk), .mdio_i(mdio_line), .mdc_o(mdc), .mdio_o(h_dout), .mdio_oe_o(h_oe));
   // verdict and end of run
   task automatic finish_test;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   // compare one value
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected value at %0t: got %h, want %h", $time, seen, want);
      end
   endtask : check
   // address frame, then a read or write frame
   task automatic acc(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] off,
                      input logic [15:0] wd);
      logic [15:0] dummy;
      mdio_host_model_i.frame(OP_ADDRESS, dev, off, dummy);
      mdio_host_model_i.frame(op, dev, wd, rd);
   endtask : acc
   task automatic rd_chk(input logic [15:0] off, input logic [15:0] want);
      acc(OP_READ, DEVAD_AN, off, 16'h0000);
      check(rd, want);
   endtask : rd_chk
   task automatic do_reset(input logic [1:0] s);
      @(posedge clk);
      rst_n <= 1'h0;
      strap <= s;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      repeat (16) @(posedge clk);
   endtask : do_reset
   // hang guard, well beyond the length of the sequence
   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   // main sequence
   initial begin
      rst_n = 1'h0;
      autoneg_enable = 1'h1;
      base_wr = 1'h0;
      base_d = 3'h0;
      lp = 6'h00;
      strap = 2'h0;
      np_low = 16'h0000;
      np_mid = 16'h0000;
      np_high = 16'h0000;
      error_cnt = 0;
      checks_done = 0;
      do_reset(2'h0);
      rd_chk(OFF_NP_MID, 16'h0000);
      rd_chk(OFF_NP_HIGH, 16'h0000);
      rd_chk(OFF_ADV_CTRL, 16'h8000);
      rd_chk(OFF_LP_STATUS, 16'h0000);
      rd_chk(OFF_FORCE, 16'h0000);
      rd_chk(16'h0210, 16'h0000);
      // advert aliases writable, energy and reserved bits stay zero
      acc(OP_WRITE, DEVAD_AN, OFF_ADV_CTRL, 16'hffff);
      rd_chk(OFF_ADV_CTRL, 16'hb000);
      check({13'h0, base_q}, 16'h0007);
      acc(OP_WRITE, DEVAD_AN, OFF_ADV_CTRL, 16'h4000);
      rd_chk(OFF_ADV_CTRL, 16'h0000);
      check({13'h0, base_q}, 16'h0000);
      // base page side write shows through the alias
      @(posedge clk);
      base_wr <= 1'h1;
      base_d  <= 3'h6;
      @(posedge clk);
      base_wr <= 1'h0;
      rd_chk(OFF_ADV_CTRL, 16'ha000);
      // forced mode enable against autoneg enable
      acc(OP_WRITE, DEVAD_AN, OFF_FORCE, 16'hffff);
      rd_chk(OFF_FORCE, 16'h0001);
      check({14'h0, forced, an_run}, 16'h0001);
      autoneg_enable <= 1'h0;
      repeat (2) @(posedge clk);
      check({14'h0, forced, an_run}, 16'h0002);
      acc(OP_WRITE, DEVAD_AN, OFF_FORCE, 16'h0000);
      check({14'h0, forced, an_run}, 16'h0000);
      // other device: ignored and not answered, wire stays pulled up
      acc(OP_WRITE, 5'h01, OFF_FORCE, 16'h0001);
      rd_chk(OFF_FORCE, 16'h0000);
      acc(OP_READ, 5'h01, OFF_ADV_CTRL, 16'h0000);
      check(rd, 16'hffff);
      // partner base page mirrors
      for (int k = 0; k < 3; k++) begin
         lp <= lp_tab[k];
         @(posedge clk);
         rd_chk(OFF_LP_STATUS, {lp_tab[k][5:2], 4'h0, lp_tab[k][1:0], 6'h00});
      end
      // snapshot taken by the low word read only
      np_low  <= 16'h9abc;
      np_mid  <= 16'h1234;
      np_high <= 16'h5678;
      @(posedge clk);
      rd_chk(OFF_NP_MID, 16'h0000);
      rd_chk(OFF_NP_LOW, 16'h9abc);
      np_mid  <= 16'hedcb;
      np_high <= 16'ha987;
      @(posedge clk);
      rd_chk(OFF_NP_MID, 16'h1234);
      rd_chk(OFF_NP_HIGH, 16'h5678);
      acc(OP_WRITE, DEVAD_AN, OFF_NP_HIGH, 16'h0ff0);
      rd_chk(OFF_NP_HIGH, 16'h5678);
      // read-increment on the low word steps the pointer onto the middle word
      acc(OP_READ_INC, DEVAD_AN, OFF_NP_LOW, 16'h0000);
      check(rd, 16'h9abc);
      np_mid <= 16'h0f0f;
      mdio_host_model_i.frame(OP_READ, DEVAD_AN, 16'h0000, rd);
      check(rd, 16'hedcb);
      // second reset with both straps high
      do_reset(2'h3);
      rd_chk(OFF_ADV_CTRL, 16'hb000);
      rd_chk(OFF_NP_MID, 16'h0000);
      finish_test();
   end
endmodule : tb_top
